// ==== logic/adc_scan_sequencer.sv ====
/*
 * scan and acquisition sequencer with its avalon-mm register slave and data buffer.
 * assumes a converter that raises a done level per conversion with data held stable,
 * and trigger, sync and done pins asynchronous to clk_i.
 */
`timescale 1ns/1ps
`include "adc_scan_consts.svh"
module adc_scan_sequencer #(
	parameter int RATE_SLOW_CYC = `CLK_HZ / `RATE_MIN_HZ,
	parameter int INTV_MAX_US   = `INTV_MAX_S * `TICK_PER_S
) (
	input  wire logic        clk_i,
	input  wire logic        srst_i,
	input  wire logic [12:0] avs_address_i,
	input  wire logic        avs_read_i,
	input  wire logic        avs_write_i,
	input  wire logic [3:0]  avs_byteenable_i,
	input  wire logic [31:0] avs_writedata_i,
	output logic      [31:0] avs_readdata_o,
	output logic             avs_waitrequest_o,
	output logic             adc_start_o,
	output logic      [5:0]  adc_chan_o,
	output logic             adc_gain_o,
	input  wire logic [15:0] adc_data_i,
	input  wire logic        adc_done_i,
	input  wire logic        trig_i,
	input  wire logic        sync_i,
	output logic             sync_o,
	output logic             irq_o
);
	localparam int RATE_RST_CYC  = `CLK_HZ / `RATE_RST_HZ;
	localparam int RATE_FAST_CYC = `CLK_HZ / `RATE_MAX_HZ;
	localparam int TICK_CYC      = `CLK_HZ / `TICK_PER_S;

	adc_scan_pkg::ctrl_t  ctrl_q;
	adc_scan_pkg::state_t st_q;
	adc_scan_pkg::state_t st_d;
	logic [16:0] rate_q;
	logic [16:0] rate_cnt_q;
	logic [29:0] intv_q;
	logic [29:0] tmr_q;
	logic [5:0]  pre_q;
	logic        armed_q;
	logic [10:0] burst_q;
	logic [10:0] burst_left_q;
	logic [15:0] ctgt_q;
	logic [15:0] scnt_q;
	logic [5:0]  chan_q;
	logic [9:0]  wp_q;
	logic [63:0] gain_q;
	logic        rdy_q;
	logic        cnt_q;
	logic        irq_q;
	logic        wait_q;
	logic [31:0] rdata_q;
	logic        start_q;
	logic [5:0]  chan_out_q;
	logic        gain_out_q;
	logic        sync_out_q;
	logic        sync_pend_q;
	logic [2:0]  done_s_q;
	logic [2:0]  trig_s_q;
	logic [2:0]  sync_s_q;
	logic [15:0] data_s1_q;
	logic [15:0] data_s2_q;
	logic [15:0] mem [1024];

	// bus decode
	wire         req      = avs_read_i | avs_write_i;
	wire         wr_fire  = avs_write_i & ~wait_q & (avs_byteenable_i == 4'hF);
	wire [31:0]  wd       = avs_writedata_i;
	wire         sel_ctrl = avs_address_i == `OFF_CTRL;
	wire         sel_rate = avs_address_i == `OFF_RATE;
	wire         sel_intv = avs_address_i == `OFF_INTV;
	wire         sel_brst = avs_address_i == `OFF_BURST;
	wire         sel_ctgt = avs_address_i == `OFF_CTGT;
	wire         sel_stat = avs_address_i == `OFF_STAT;
	wire         sel_scnt = avs_address_i == `OFF_SCNT;
	wire         sel_wptr = avs_address_i == `OFF_WPTR;
	wire         sel_cmd  = avs_address_i == `OFF_CMD;
	wire         sel_gain = (avs_address_i[12:8] == `GAIN_PAGE) & (avs_address_i[1:0] == 2'h0);
	wire         sel_data = avs_address_i[`DATA_BIT] & (avs_address_i[1:0] == 2'h0);
	wire [5:0]   gidx     = avs_address_i[7:2];
	wire [9:0]   didx     = avs_address_i[11:2];
	wire         ctrl_wr  = wr_fire & sel_ctrl;
	wire         intv_wr  = wr_fire & sel_intv;
	wire         stat_wr  = wr_fire & sel_stat;
	wire         soft_trig = wr_fire & sel_cmd & wd[`CMD_TRIG];

	// clamped write values keep each setting but the count target inside its legal range; the 400-cycle reset rate lies under the 800-cycle floor
	wire [16:0]  rate_wv = (wd < 32'(RATE_FAST_CYC)) ? 17'(RATE_FAST_CYC) :
	                       (wd > 32'(RATE_SLOW_CYC)) ? 17'(RATE_SLOW_CYC) : wd[16:0];
	wire [29:0]  intv_wv = (wd == 32'h0000_0000) ? 30'h0000_0001 :
	                       (wd > 32'(INTV_MAX_US)) ? 30'(INTV_MAX_US) : wd[29:0];
	wire [10:0]  brst_wv = (wd < 32'(`BURST_MIN)) ? `BURST_MIN :
	                       (wd > 32'(`BURST_MAX)) ? `BURST_MAX : wd[10:0];
	wire [3:0]   blog_wv = (wd[12:9] < `BUF_LOG_MIN) ? `BUF_LOG_MIN :
	                       (wd[12:9] > `BUF_LOG_MAX) ? `BUF_LOG_MAX : wd[12:9];
	wire [2:0]   bsel_wv = (wd[15:13] > `BLK_SEL_MAX) ? `BLK_SEL_MAX : wd[15:13];
	wire adc_scan_pkg::ctrl_t ctrl_wv = {bsel_wv, blog_wv, wd[8:0]};

	// block and buffer geometry
	wire [5:0]   blk_last = (ctrl_q.blk_sel == 3'h0) ? 6'h00 : (ctrl_q.blk_sel == 3'h1) ? 6'h07 :
	                        (ctrl_q.blk_sel == 3'h2) ? 6'h0F : (ctrl_q.blk_sel == 3'h3) ? 6'h1F : 6'h3F;
	wire [5:0]   mid_last = {1'b0, blk_last[5:1]};
	wire [9:0]   bmask    = 10'((11'h001 << ctrl_q.buf_log2) - 11'h001);

	// input edges, taken from the second and third flops only
	wire         done_rise = done_s_q[1] & ~done_s_q[2];
	wire         trig_rise = trig_s_q[1] & ~trig_s_q[2];
	wire         sync_rise = sync_s_q[1] & ~sync_s_q[2];

	// timer and burst launch
	wire         tick     = pre_q == 6'(TICK_CYC - 1);
	wire         tmr_run  = armed_q & (ctrl_q.mode == adc_scan_pkg::MODE_TIMED);
	wire         tmr_fire = tmr_run & tick & (tmr_q == intv_q - 30'h0000_0001);
	wire         burst_go = (ctrl_q.mode == adc_scan_pkg::MODE_TIMED) ? tmr_fire :
	                        (ctrl_q.mode == adc_scan_pkg::MODE_TRIG) ? (trig_rise | soft_trig) : 1'b0;
	wire         active   = (ctrl_q.mode == adc_scan_pkg::MODE_AUTO) |
	                        ((ctrl_q.mode != adc_scan_pkg::MODE_HALT) & (burst_left_q != 11'h000));

	// pacing: scan start waits for the sync edge when slaved
	wire         rate_hit = rate_cnt_q == 17'h0_0000;
	wire         scan_ok  = (chan_q != 6'h00) | ~ctrl_q.ext_sync | sync_pend_q;
	wire         go       = rate_hit & scan_ok;
	wire         launch   = (st_q == adc_scan_pkg::ST_WAIT) & (st_d == adc_scan_pkg::ST_CONV);
	wire         smp_done = (st_q == adc_scan_pkg::ST_CONV) & done_rise & ~ctrl_wr;
	wire         gain_sel = ctrl_q.fix_en ? ctrl_q.fix_gain : gain_q[chan_q];

	// flags: a set in the same cycle as the clear wins
	wire         rdy_set = smp_done & (chan_q == (ctrl_q.mid_sel ? mid_last : blk_last));
	wire         cnt_set = smp_done & ((scnt_q + 16'h0001) == ctgt_q);
	wire         rdy_d   = rdy_set | (rdy_q & ~(stat_wr & wd[`STAT_RDY]));
	wire         cnt_d   = cnt_set | (cnt_q & ~(stat_wr & wd[`STAT_CNT]));

	wire [31:0]  rd_val =
		sel_ctrl ? {16'h0000, ctrl_q} :
		sel_rate ? {15'h0000, rate_q} :
		sel_intv ? {2'h0, intv_q} :
		sel_brst ? {21'h00_0000, burst_q} :
		sel_ctgt ? {16'h0000, ctgt_q} :
		sel_stat ? {29'h0000_0000, st_q != adc_scan_pkg::ST_IDLE, cnt_q, rdy_q} :
		sel_scnt ? {16'h0000, scnt_q} :
		sel_wptr ? {22'h00_0000, wp_q} :
		sel_gain ? {31'h0000_0000, gain_q[gidx]} :
		sel_data ? {16'h0000, mem[didx]} : 32'h0000_0000;

	always_comb begin
		st_d = st_q;
		unique case (st_q)
			adc_scan_pkg::ST_IDLE: begin
				if (active) st_d = adc_scan_pkg::ST_WAIT;
			end
			adc_scan_pkg::ST_WAIT: begin
				if (!active) st_d = adc_scan_pkg::ST_IDLE;
				else if (go) st_d = adc_scan_pkg::ST_CONV;
			end
			adc_scan_pkg::ST_CONV: begin
				if (done_rise) st_d = adc_scan_pkg::ST_WAIT;
			end
			default: st_d = adc_scan_pkg::ST_IDLE;
		endcase
		// a new configuration drops any conversion in flight
		if (ctrl_wr) st_d = adc_scan_pkg::ST_IDLE;
	end

	// slave: one wait cycle, then a one-cycle acknowledge
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			wait_q  <= 1'b1;
			rdata_q <= 32'h0000_0000;
		end else begin
			wait_q <= ~(req & wait_q);
			if (avs_read_i & wait_q) rdata_q <= rd_val;
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			ctrl_q  <= `CTRL_RST;
			rate_q  <= 17'(RATE_RST_CYC);
			intv_q  <= `INTV_RST;
			burst_q <= `BURST_RST;
			ctgt_q  <= `CTGT_RST;
		end else begin
			if (ctrl_wr) ctrl_q <= ctrl_wv;
			if (wr_fire & sel_rate) rate_q <= rate_wv;
			if (intv_wr) intv_q <= intv_wv;
			if (wr_fire & sel_brst) burst_q <= brst_wv;
			if (wr_fire & sel_ctgt) ctgt_q <= wd[15:0];
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) gain_q <= 64'h0000_0000_0000_0000;
		else if (wr_fire & sel_gain) gain_q[gidx] <= wd[0];
	end

	always_ff @(posedge clk_i) begin
		done_s_q  <= {done_s_q[1:0], adc_done_i};
		trig_s_q  <= {trig_s_q[1:0], trig_i};
		sync_s_q  <= {sync_s_q[1:0], sync_i};
		data_s1_q <= adc_data_i;
		data_s2_q <= data_s1_q;
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			pre_q   <= 6'h00;
			tmr_q   <= 30'h0000_0000;
			armed_q <= 1'b1;
		end else begin
			pre_q <= tick ? 6'h00 : pre_q + 6'h01;
			if (!tmr_run) tmr_q <= 30'h0000_0000;
			else if (tick) tmr_q <= tmr_fire ? 30'h0000_0000 : tmr_q + 30'h0000_0001;
			// single shot disarms until the interval or control is rewritten
			if (ctrl_wr | intv_wr) armed_q <= 1'b1;
			else if (tmr_fire & ~ctrl_q.tmr_rep) armed_q <= 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			st_q         <= adc_scan_pkg::ST_IDLE;
			rate_cnt_q   <= 17'h0_0000;
			burst_left_q <= 11'h000;
			sync_pend_q  <= 1'b0;
		end else begin
			st_q       <= st_d;
			rate_cnt_q <= rate_hit ? rate_q - 17'h0_0001 : rate_cnt_q - 17'h0_0001;
			if (ctrl_wr) burst_left_q <= 11'h000;
			else if (burst_go & (burst_left_q == 11'h000)) burst_left_q <= burst_q;
			else if (smp_done & (burst_left_q != 11'h000)) burst_left_q <= burst_left_q - 11'h001;
			sync_pend_q <= sync_rise | (sync_pend_q & ~(launch & (chan_q == 6'h00)));
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i | ctrl_wr) begin
			chan_q <= 6'h00;
			wp_q   <= 10'h000;
			scnt_q <= 16'h0000;
		end else if (smp_done) begin
			chan_q <= (chan_q == blk_last) ? 6'h00 : chan_q + 6'h01;
			wp_q   <= (wp_q + 10'h001) & bmask;
			scnt_q <= cnt_set ? 16'h0000 : scnt_q + 16'h0001;
		end
	end

	// buffer port a: sequencer writes; the bus reads the other side freely
	always_ff @(posedge clk_i) begin
		if (smp_done) mem[wp_q] <= data_s2_q;
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			rdy_q      <= 1'b0;
			cnt_q      <= 1'b0;
			irq_q      <= 1'b0;
			start_q    <= 1'b0;
			chan_out_q <= 6'h00;
			gain_out_q <= 1'b0;
			sync_out_q <= 1'b0;
		end else begin
			rdy_q      <= rdy_d;
			cnt_q      <= cnt_d;
			irq_q      <= (rdy_d & ctrl_q.irq_en) | (cnt_d & ctrl_q.cnt_irq);
			start_q    <= launch;
			sync_out_q <= launch & (chan_q == 6'h00);
			if (launch) begin
				chan_out_q <= chan_q;
				gain_out_q <= gain_sel;
			end
		end
	end

	assign avs_readdata_o    = rdata_q;
	assign avs_waitrequest_o = wait_q;
	assign adc_start_o       = start_q;
	assign adc_chan_o        = chan_out_q;
	assign adc_gain_o        = gain_out_q;
	assign sync_o            = sync_out_q;
	assign irq_o             = irq_q;

	sequence s_req_waits;
		req && wait_q;
	endsequence
	sequence s_ack_once;
		!wait_q ##1 wait_q;
	endsequence

	AST_RST_DEFAULTS: assert property (@(posedge clk_i) disable iff (srst_i)
		$fell(srst_i) |-> ctrl_q == `CTRL_RST && rate_q == 17'(RATE_RST_CYC))
		else $error("reset defaults wrong");
	AST_GAIN_RST: assert property (@(posedge clk_i) disable iff (srst_i)
		$fell(srst_i) |-> gain_q == 64'h0000_0000_0000_0000)
		else $error("gain table not cleared by reset");
	AST_BUS_ACK: assert property (@(posedge clk_i) disable iff (srst_i)
		s_req_waits |=> s_ack_once)
		else $error("bus answer not a single ack cycle");
	AST_IRQ_WITH_FLAG: assert property (@(posedge clk_i) disable iff (srst_i)
		$rose(rdy_q) && $past(ctrl_q.irq_en) |-> irq_o)
		else $error("irq late against data-ready");
	AST_BLOCK_WRAP: assert property (@(posedge clk_i) disable iff (srst_i)
		smp_done && chan_q == blk_last |=> chan_q == 6'h00)
		else $error("channel did not wrap at block end");
	AST_BUF_WRAP: assert property (@(posedge clk_i) disable iff (srst_i)
		smp_done && wp_q == bmask |=> wp_q == 10'h000)
		else $error("buffer pointer did not wrap");
	AST_STORE: assert property (@(posedge clk_i) disable iff (srst_i)
		smp_done |=> mem[$past(wp_q)] == $past(data_s2_q))
		else $error("sample not stored");
	AST_BURST_LOAD: assert property (@(posedge clk_i) disable iff (srst_i)
		burst_go && burst_left_q == 11'h000 && !ctrl_wr |=> burst_left_q == $past(burst_q))
		else $error("burst length not loaded");
	AST_CNT_IRQ: assert property (@(posedge clk_i) disable iff (srst_i)
		cnt_set && ctrl_q.cnt_irq && !ctrl_wr |=> irq_o && cnt_q && scnt_q == 16'h0000)
		else $error("count interrupt missing");
	AST_SYNC_GATE: assert property (@(posedge clk_i) disable iff (srst_i)
		launch && chan_q == 6'h00 && ctrl_q.ext_sync |-> sync_pend_q ##1 sync_o)
		else $error("scan started without sync");

	sequence s_ch0_start;
		adc_start_o && adc_chan_o == 6'h00;
	endsequence

	AST_SET_WINS: assert property (@(posedge clk_i) disable iff (srst_i)
		rdy_set |=> rdy_q)
		else $error("ready flag lost against its clear");
	AST_START_PULSE: assert property (@(posedge clk_i) disable iff (srst_i)
		adc_start_o |=> !adc_start_o)
		else $error("start longer than one cycle");
	AST_SYNC_OUT: assert property (@(posedge clk_i) disable iff (srst_i)
		sync_o |-> s_ch0_start)
		else $error("sync out without a channel 0 start");
	AST_FIX_GAIN: assert property (@(posedge clk_i) disable iff (srst_i)
		launch && ctrl_q.fix_en |=> adc_gain_o == $past(ctrl_q.fix_gain))
		else $error("fixed gain not applied");
	AST_RATE_CLAMP: assert property (@(posedge clk_i) disable iff (srst_i)
		wr_fire && sel_rate |=> rate_q >= 17'(RATE_FAST_CYC) && rate_q <= 17'(RATE_SLOW_CYC))
		else $error("rate outside its range");
	AST_INTV_CLAMP: assert property (@(posedge clk_i) disable iff (srst_i)
		intv_wr |=> intv_q != 30'h0000_0000 && intv_q <= 30'(INTV_MAX_US))
		else $error("interval outside its range");
	AST_GEOMETRY: assert property (@(posedge clk_i) disable iff (srst_i)
		ctrl_q.buf_log2 >= `BUF_LOG_MIN && ctrl_q.buf_log2 <= `BUF_LOG_MAX && ctrl_q.blk_sel <= `BLK_SEL_MAX)
		else $error("buffer or block size illegal");
	AST_BURST_LEGAL: assert property (@(posedge clk_i) disable iff (srst_i)
		burst_q >= `BURST_MIN && burst_q <= `BURST_MAX)
		else $error("burst length illegal");
	AST_CTRL_RESTART: assert property (@(posedge clk_i) disable iff (srst_i)
		ctrl_wr |=> st_q == adc_scan_pkg::ST_IDLE && chan_q == 6'h00 && wp_q == 10'h000 && burst_left_q == 11'h000)
		else $error("control write did not restart the scan");
	AST_READ_DATA: assert property (@(posedge clk_i) disable iff (srst_i)
		avs_read_i && wait_q |=> avs_readdata_o == $past(rd_val))
		else $error("read data not captured");
endmodule : adc_scan_sequencer

// ==== logic/adc_scan_consts.svh ====
/*
 * offsets, field positions, reset values and timing figures of the scan sequencer.
 * assumes a 13-bit avalon byte address and a 40 MHz clock.
 */
`ifndef ADC_SCAN_CONSTS_SVH
`define ADC_SCAN_CONSTS_SVH
`define CLK_HZ      40000000
`define RATE_RST_HZ 100000
`define RATE_MAX_HZ 50000
`define RATE_MIN_HZ 381
`define TICK_PER_S  1000000
`define INTV_MAX_S  687
`define OFF_CTRL    13'h0000
`define OFF_RATE    13'h0004
`define OFF_INTV    13'h0008
`define OFF_BURST   13'h000C
`define OFF_CTGT    13'h0010
`define OFF_STAT    13'h0014
`define OFF_SCNT    13'h0018
`define OFF_WPTR    13'h001C
`define OFF_CMD     13'h0020
`define GAIN_PAGE   5'h01
`define DATA_BIT    12
`define STAT_RDY    0
`define STAT_CNT    1
`define STAT_BUSY   2
`define CMD_TRIG    0
`define CTRL_RST    16'h9400
`define BURST_RST   11'h040
`define CTGT_RST    16'h0400
`define INTV_RST    30'h000F_4240
`define BURST_MIN   11'h008
`define BURST_MAX   11'h400
`define BUF_LOG_MIN 4'h4
`define BUF_LOG_MAX 4'hA
`define BLK_SEL_MAX 3'h4
`endif

// ==== logic/adc_scan_pkg.sv ====
/*
 * types of the scan sequencer: modes, sequencer states, control word layout.
 * assumes nothing of its surroundings.
 */
package adc_scan_pkg;
	typedef enum logic [1:0] {
		MODE_AUTO  = 2'b00,
		MODE_TIMED = 2'b01,
		MODE_TRIG  = 2'b10,
		MODE_HALT  = 2'b11
	} mode_t;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_WAIT = 2'b01,
		ST_CONV = 2'b10
	} state_t;
	typedef struct packed {
		logic [2:0] blk_sel;
		logic [3:0] buf_log2;
		logic       ext_sync;
		logic       tmr_rep;
		logic       cnt_irq;
		logic       irq_en;
		logic       mid_sel;
		logic       fix_gain;
		logic       fix_en;
		mode_t      mode;
	} ctrl_t;
endpackage : adc_scan_pkg

// ==== bench/adc_conv_model.sv ====
/*
 * converter model: answers each start pulse with a done level and a sample word.
 * assumes start, channel and gain come from the sequencer on the same clock.
 */
`timescale 1ns/1ps
module adc_conv_model (
	input  wire logic        clk_i,
	input  wire logic        start_i,
	input  wire logic [5:0]  chan_i,
	input  wire logic        gain_i,
	input  wire logic        slow_i,
	output logic      [15:0] data_o,
	output logic             done_o
);
	logic [5:0] ch_q;
	logic       g_q;
	int         wait_q;
	int         hold_q;
	initial begin
		data_o = 16'h0000;
		done_o = 1'b0;
		wait_q = 0;
		hold_q = 0;
	end
	// data turns over once done drops, so a stale sample never passes for a fresh one
	always @(posedge clk_i) begin
		if (start_i) begin
			ch_q   <= chan_i;
			g_q    <= gain_i;
			wait_q <= slow_i ? 300 : 20;
		end else if (wait_q > 0) begin
			wait_q <= wait_q - 1;
			if (wait_q == 1) begin
				data_o <= {g_q, 3'h5, ch_q, 6'h15};
				done_o <= 1'b1;
				hold_q <= 6;
			end
		end else if (hold_q > 0) begin
			hold_q <= hold_q - 1;
			if (hold_q == 1) begin
				data_o <= ~data_o;
				done_o <= 1'b0;
			end
		end
	end
endmodule : adc_conv_model

// ==== bench/adc_scan_sequencer_tb_top.sv ====
/*
 * self-checking bench of the scan sequencer: register bus master, start monitor, scenarios.
 * assumes the converter model beside it and shortened rate and interval limits.
 */
`timescale 1ns/1ps
`include "adc_scan_consts.svh"
module adc_scan_sequencer_tb_top;
	localparam int SLOW = 1000;
	localparam int RST_CYC = `CLK_HZ / `RATE_RST_HZ;
	localparam int MAX_CYC = `CLK_HZ / `RATE_MAX_HZ;
	localparam logic [6:0] F_FIX = 7'h03;
	localparam logic [6:0] F_MID = 7'h04;
	localparam logic [6:0] F_IRQ = 7'h08;
	localparam logic [6:0] F_CNT = 7'h10;
	localparam logic [6:0] F_SYN = 7'h40;
	logic        clk_i, srst_i, avs_read_i, avs_write_i, avs_waitrequest_o;
	logic [12:0] avs_address_i;
	logic [3:0]  avs_byteenable_i;
	logic [31:0] avs_writedata_i, avs_readdata_o, r;
	logic        adc_start_o, adc_gain_o, adc_done_i, trig_i, sync_i, sync_o, irq_o, slow, lgain;
	logic [5:0]  adc_chan_o, lchan;
	logic [15:0] adc_data_i;
	int          n_fail, compares, cyc, n_start, n_sync, gap, last, k;
	adc_scan_sequencer #(.RATE_SLOW_CYC(SLOW), .INTV_MAX_US(100)) adc_scan_sequencer_i (
		.clk_i(clk_i), .srst_i(srst_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
		.avs_write_i(avs_write_i), .avs_byteenable_i(avs_byteenable_i), .avs_writedata_i(avs_writedata_i),
		.avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o), .adc_start_o(adc_start_o),
		.adc_chan_o(adc_chan_o), .adc_gain_o(adc_gain_o), .adc_data_i(adc_data_i), .adc_done_i(adc_done_i),
		.trig_i(trig_i), .sync_i(sync_i), .sync_o(sync_o), .irq_o(irq_o));
	adc_conv_model adc_conv_model_i (.clk_i(clk_i), .start_i(adc_start_o), .chan_i(adc_chan_o),
		.gain_i(adc_gain_o), .slow_i(slow), .data_o(adc_data_i), .done_o(adc_done_i));
	initial begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (adc_start_o === 1'b1) begin
			n_start <= n_start + 1;
			gap     <= cyc - last;
			last    <= cyc;
			lchan   <= adc_chan_o;
			lgain   <= adc_gain_o;
		end
		if (sync_o === 1'b1)
			n_sync <= n_sync + 1;
	end
	task automatic final_report;
		$display("comparisons %0d mismatches %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : final_report
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic bus(input logic w, input logic [3:0] be, input logic [12:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		avs_address_i    <= a;
		avs_byteenable_i <= be;
		avs_writedata_i  <= d;
		avs_write_i      <= w;
		avs_read_i       <= !w;
		do begin
			@(posedge clk_i);
			n++;
		end while (avs_waitrequest_o !== 1'b0 && n < 100);
		r = avs_readdata_o;
		avs_read_i  <= 1'b0;
		avs_write_i <= 1'b0;
		chk(n, 2);
	endtask : bus
	task automatic wr(input logic [12:0] a, input logic [31:0] d);
		bus(1'b1, 4'hF, a, d);
	endtask : wr
	task automatic rdc(input logic [12:0] a, input logic [31:0] exp);
		bus(1'b0, 4'hF, a, 32'h0000_0000);
		chk(r, exp);
	endtask : rdc
	task automatic ctl(input logic [2:0] blk, input logic [6:0] fl, input logic [1:0] m);
		wr(`OFF_STAT, 32'h0000_0003);
		wr(`OFF_CTRL, {16'h0000, blk, 4'hA, fl, m});
	endtask : ctl
	task automatic starts(input int n);
		int i;
		i = n_start + n;
		for (int j = 0; j < n * 1000 + 3000 && n_start < i; j++)
			@(negedge clk_i);
	endtask : starts
	task automatic wait_irq;
		for (int j = 0; j < 12000 && irq_o !== 1'b1; j++)
			@(negedge clk_i);
		chk(irq_o, 1'b1);
	endtask : wait_irq
	task automatic pulse(input logic to_sync);
		@(posedge clk_i);
		if (to_sync) sync_i <= 1'b1;
		else trig_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		sync_i <= 1'b0;
		trig_i <= 1'b0;
	endtask : pulse
	task automatic t_reset;
		rdc(`OFF_CTRL, {16'h0000, `CTRL_RST});
		rdc(`OFF_RATE, RST_CYC);
		rdc(13'h0100, 32'h0000_0000);
		rdc(13'h01FC, 32'h0000_0000);
		rdc(13'h0024, 32'h0000_0000);
		starts(2);
		chk(gap, RST_CYC);
		k = lchan;
		starts(1);
		chk(lchan, 6'(k + 1));
	endtask : t_reset
	task automatic t_rate;
		wr(`OFF_RATE, MAX_CYC);
		starts(3);
		chk(gap, MAX_CYC);
		bus(1'b1, 4'h3, `OFF_RATE, 32'h0000_1388);
		rdc(`OFF_RATE, MAX_CYC);
		wr(`OFF_RATE, 32'h0000_000A);
		rdc(`OFF_RATE, MAX_CYC);
		wr(`OFF_RATE, 32'h0000_1388);
		rdc(`OFF_RATE, SLOW);
		wr(`OFF_RATE, MAX_CYC);
	endtask : t_rate
	task automatic t_wrap;
		wr(`OFF_STAT, 32'h0000_0003);
		wr(`OFF_CTRL, {16'h0000, 3'h3, 4'h4, 7'h00, 2'b00});
		for (int i = 0; i < 17; i++) begin
			starts(1);
			chk(lchan, i);
		end
		repeat (40) @(negedge clk_i);
		rdc(`OFF_WPTR, 32'h0000_0001);
		rdc(13'h1000, {16'h0000, 1'b0, 3'h5, 6'h10, 6'h15});
		rdc(13'h1004, {16'h0000, 1'b0, 3'h5, 6'h01, 6'h15});
	endtask : t_wrap
	task automatic t_block;
		ctl(3'h1, 7'h00, 2'b00);
		starts(8);
		chk(lchan, 6'h07);
		starts(1);
		chk(lchan, 6'h00);
		ctl(3'h0, 7'h00, 2'b00);
		starts(2);
		chk(lchan, 6'h00);
	endtask : t_block
	task automatic t_gain;
		wr(13'h0104, 32'h0000_0001);
		ctl(3'h1, 7'h00, 2'b00);
		starts(1);
		chk(lgain, 1'b0);
		starts(1);
		chk({lchan, lgain}, {6'h01, 1'b1});
		repeat (40) @(negedge clk_i);
		rdc(13'h1004, {16'h0000, 1'b1, 3'h5, 6'h01, 6'h15});
		ctl(3'h1, F_FIX, 2'b00);
		starts(1);
		chk(lgain, 1'b1);
		wr(13'h0104, 32'h0000_0000);
	endtask : t_gain
	task automatic t_flag;
		ctl(3'h1, F_IRQ, 2'b00);
		wait_irq();
		chk(adc_chan_o, 6'h07);
		bus(1'b0, 4'hF, `OFF_STAT, 32'h0000_0000);
		chk(r[0], 1'b1);
		wr(`OFF_STAT, 32'h0000_0001);
		repeat (3) @(negedge clk_i);
		chk(irq_o, 1'b0);
		ctl(3'h1, F_IRQ | F_MID, 2'b00);
		wait_irq();
		chk(adc_chan_o, 6'h03);
	endtask : t_flag
	task automatic t_count;
		wr(`OFF_CTGT, 32'h0000_0005);
		ctl(3'h4, F_CNT, 2'b00);
		wait_irq();
		chk(adc_chan_o, 6'h04);
		bus(1'b0, 4'hF, `OFF_STAT, 32'h0000_0000);
		chk(r[1], 1'b1);
	endtask : t_count
	task automatic t_burst;
		wr(`OFF_BURST, 32'h0000_0004);
		rdc(`OFF_BURST, 32'h0000_0008);
		slow <= 1'b1;
		ctl(3'h4, 7'h00, 2'b10);
		k = n_start;
		repeat (1000) @(negedge clk_i);
		chk(n_start - k, 0);
		pulse(1'b0);
		repeat (7400) @(negedge clk_i);
		chk(n_start - k, 8);
		k = n_start;
		wr(`OFF_CMD, 32'h0000_0001);
		repeat (7400) @(negedge clk_i);
		chk(n_start - k, 8);
		slow <= 1'b0;
	endtask : t_burst
	task automatic t_timed;
		wr(`OFF_INTV, 32'h0000_1388);
		rdc(`OFF_INTV, 32'h0000_0064);
		wr(`OFF_INTV, 32'h0000_0032);
		ctl(3'h4, 7'h00, 2'b01);
		k = n_start;
		repeat (1500) @(negedge clk_i);
		chk(n_start - k, 0);
		repeat (11000) @(negedge clk_i);
		chk(n_start - k, 8);
	endtask : t_timed
	task automatic t_sync;
		ctl(3'h1, F_SYN, 2'b00);
		k = n_start;
		repeat (1500) @(negedge clk_i);
		chk(n_start - k, 0);
		k = n_sync;
		pulse(1'b1);
		starts(1);
		chk(lchan, 6'h00);
		repeat (3) @(negedge clk_i);
		chk(n_sync - k, 1);
	endtask : t_sync
	task automatic t_halt;
		rdc(`OFF_STAT, 32'h0000_0004);
		ctl(3'h1, 7'h00, 2'b11);
		k = n_start;
		repeat (1000) @(negedge clk_i);
		chk(n_start - k, 0);
		rdc(`OFF_STAT, 32'h0000_0000);
	endtask : t_halt
	initial begin
		repeat (99000) @(posedge clk_i);
		n_fail++;
		final_report();
	end
	initial begin
		{avs_read_i, avs_write_i, trig_i, sync_i, slow} = 5'h00;
		{n_fail, compares, cyc, n_start, n_sync, gap, last} = '0;
		avs_address_i = 13'h0000;
		avs_byteenable_i = 4'hF;
		avs_writedata_i = 32'h0000_0000;
		srst_i = 1'b1;
		repeat (8) @(posedge clk_i);
		srst_i <= 1'b0;
		t_reset();
		t_rate();
		t_wrap();
		t_block();
		t_gain();
		t_flag();
		t_count();
		t_burst();
		t_timed();
		t_sync();
		t_halt();
		final_report();
	end
endmodule : adc_scan_sequencer_tb_top
